// [input_port_defines.svh]
// Constants for the four-pin input port block: register map, bit positions,
// reset values and bus widths.
// Assumes an Avalon-MM slave with 32-bit data and byte addresses.
`ifndef INPUT_PORT_DEFINES_SVH
`define INPUT_PORT_DEFINES_SVH

`define PIN_COUNT 4
`define ADDR_W 5
`define DATA_W 32

// Register byte offsets
`define OFF_LEVELS 5'h00
`define OFF_ENABLE 5'h04
`define OFF_PENDING 5'h08
`define OFF_POLARITY 5'h0c
`define OFF_BYPASS 5'h10
`define OFF_INHIBIT 5'h14
`define OFF_DIVIDER 5'h18
`define OFF_WAKE 5'h1c

// Field positions
`define PORT_LSB 0
`define PORT_MSB 3
`define DEB_CLK_SEL_BIT 0
`define LANE0_BIT 0

// Reset values
`define ENABLE_RST 4'h0
`define PENDING_RST 4'h0
`define POLARITY_RST 4'h0
`define BYPASS_RST 4'h0
`define INHIBIT_RST 4'h0
`define WAKE_RST 4'h0
`define PORT_ZERO 4'h0
`define READ_ZERO 32'h0000_0000

// Mask options for fitted pull resistors
`define PULLUP_FITTED_DEF 4'h0
`define PULLDOWN_FITTED_DEF 4'hf

`endif

// [input_port_irq_debounce.sv]
// Four-pin input port: readback, debounce, edge requests, pull control,
// branch-test, event-clock and start/stop outputs, wake-up detection.
// Assumes pins and prescaler taps synchronous to clk_sys, an Avalon-MM
// master with byte addresses, and an outside interrupt controller.
//
// Operation
// - Software reads the four current pin levels at any time.
// - Every setting except the debounce clock select is held per pin and, apart from the wake pattern, applied separately for each pin.
// - In sleep, a match with a nonzero wake pattern raises wake one clock later.
// - Pull enables keep their setting during sleep.
// - Edge detector takes raw or debounced input per pin.
// - Debouncer accepts a level stable over two debounce clock rises.
// - Each pin requests on rising or falling edge per its polarity bit.
// - All four pins request, each gated by its own enable bit.
// - Reset clears all four enable bits.
// - Only edges after enabling set a flag; masked edges are lost.
// - Pending flags are readable by software.
// - Polarity change onto the active level raises a request.
// - Pull is on when inhibit bit is 0 and only that resistor is fitted.
// - Pull-up and pull-down are never both on.
// - Pins 0 to 2 feed branch tests, debounced and non-inverted.
// - Pin 0 to test one, pin 1 to two, pin 2 to three.
// - Pins 0 and 3 give event clocks with bypass and polarity.
// - Pin 3 raw pad level drives millisecond counter start/stop.
// - Writing 1 clears a pending flag; 0 leaves it.
// - Enable bit 0 blocks storing requests; 1 allows them.
// - Polarity 0 selects rising edge, 1 selects falling edge.
// - Debounce clock is 128 Hz tap at select 0, 1024 Hz at 1.
`timescale 1ns/10ps
`include "input_port_defines.svh"

module input_port_irq_debounce #(
  parameter logic [3:0] pullup_fitted_option = `PULLUP_FITTED_DEF,
  parameter logic [3:0] pulldown_fitted_option = `PULLDOWN_FITTED_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [`DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] input_port,
  input wire logic tap_128hz,
  input wire logic tap_1024hz,
  input wire logic sleep_mode,
  output logic [3:0] pin_irq_pending_flags,
  output logic [3:0] pullup_en,
  output logic [3:0] pulldown_en,
  output logic branch_test_one,
  output logic branch_test_two,
  output logic branch_test_three,
  output logic event_clk_pin0,
  output logic event_clk_pin3,
  output logic millisecond_counter_run,
  output logic wake_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request and handshake
  input_port_pkg::bus_req_t req;
  logic wait_r;
  logic wait_nxt;
  logic [`DATA_W-1:0] rdata_r;
  logic [`DATA_W-1:0] rdata_nxt;
  wire any_req;
  wire take_req;
  wire accept;
  wire wr_acc;
  wire lane0;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};
  assign any_req = req.read || req.write;
  // First cycle of a request: read data are prepared here
  assign take_req = any_req && wait_r;
  // Second cycle: waitrequest low, write takes effect
  assign accept = any_req && !wait_r;
  assign lane0 = req.byteenable[`LANE0_BIT];
  assign wr_acc = accept && req.write && lane0;
  assign wait_nxt = !take_req;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  input_port_pkg::port_cfg_t cfg_r;
  input_port_pkg::pin_vec_t pend_r;
  input_port_pkg::pin_vec_t pend_nxt;
  input_port_pkg::pin_vec_t wake_pat_r;
  logic deb_sel_r;
  wire [3:0] wdata4;
  wire wr_enable;
  wire wr_pending;
  wire wr_polarity;
  wire wr_bypass;
  wire wr_inhibit;
  wire wr_divider;
  wire wr_wake;

  assign wdata4 = req.writedata[`PORT_MSB:`PORT_LSB];
  assign wr_enable = wr_acc && (req.address == `OFF_ENABLE);
  assign wr_pending = wr_acc && (req.address == `OFF_PENDING);
  assign wr_polarity = wr_acc && (req.address == `OFF_POLARITY);
  assign wr_bypass = wr_acc && (req.address == `OFF_BYPASS);
  assign wr_inhibit = wr_acc && (req.address == `OFF_INHIBIT);
  assign wr_divider = wr_acc && (req.address == `OFF_DIVIDER);
  assign wr_wake = wr_acc && (req.address == `OFF_WAKE);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_r.enable <= `ENABLE_RST;
      cfg_r.polarity <= `POLARITY_RST;
      cfg_r.bypass <= `BYPASS_RST;
      cfg_r.inhibit <= `INHIBIT_RST;
      deb_sel_r <= 1'b0;
      wake_pat_r <= `WAKE_RST;
    end else begin
      if (wr_enable) cfg_r.enable <= wdata4;
      if (wr_polarity) cfg_r.polarity <= wdata4;
      if (wr_bypass) cfg_r.bypass <= wdata4;
      if (wr_inhibit) cfg_r.inhibit <= wdata4;
      if (wr_divider) deb_sel_r <= req.writedata[`DEB_CLK_SEL_BIT];
      if (wr_wake) wake_pat_r <= wdata4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and debounce clock tick
  input_port_pkg::pin_vec_t sync1_r;
  input_port_pkg::pin_vec_t raw_r;
  input_port_pkg::pin_vec_t deb_lvl;
  logic tap_prev_r;
  wire tap_sel;
  wire deb_tick;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_r <= `PORT_ZERO;
      raw_r <= `PORT_ZERO;
      tap_prev_r <= 1'b0;
    end else begin
      sync1_r <= input_port;
      raw_r <= sync1_r;
      tap_prev_r <= tap_sel;
    end
  end

  assign tap_sel = deb_sel_r ? tap_1024hz : tap_128hz;
  assign deb_tick = tap_sel && !tap_prev_r;

  pin_debouncer u_debouncer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .raw_lvl(raw_r),
    .deb_tick(deb_tick),
    .deb_lvl(deb_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin edge detection and request flags
  input_port_pkg::pin_vec_t chosen;
  input_port_pkg::pin_vec_t oriented;
  input_port_pkg::pin_vec_t oriented_prev_r;
  input_port_pkg::pin_vec_t edge_hit;

  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
      assign chosen[i] = cfg_r.bypass[i] ? raw_r[i] : deb_lvl[i];
      // Inverting for falling edges turns every active edge into a rise
      assign oriented[i] = chosen[i] ^ cfg_r.polarity[i];
      assign edge_hit[i] = oriented[i] && !oriented_prev_r[i];
      // Set wins over a simultaneous write-one clear
      assign pend_nxt[i] = (edge_hit[i] && cfg_r.enable[i])
                        || (pend_r[i] && !(wr_pending && wdata4[i]));
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oriented_prev_r <= `PORT_ZERO;
      pend_r <= `PENDING_RST;
    end else begin
      oriented_prev_r <= oriented;
      pend_r <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  assign rdata_nxt = (req.address == `OFF_LEVELS) ? {28'h0, raw_r} :
                     (req.address == `OFF_ENABLE) ? {28'h0, cfg_r.enable} :
                     (req.address == `OFF_PENDING) ? {28'h0, pend_r} :
                     (req.address == `OFF_POLARITY) ? {28'h0, cfg_r.polarity} :
                     (req.address == `OFF_BYPASS) ? {28'h0, cfg_r.bypass} :
                     (req.address == `OFF_INHIBIT) ? {28'h0, cfg_r.inhibit} :
                     (req.address == `OFF_DIVIDER) ? {31'h0, deb_sel_r} :
                     (req.address == `OFF_WAKE) ? {28'h0, wake_pat_r} :
                     `READ_ZERO;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= `READ_ZERO;
    end else begin
      wait_r <= wait_nxt;
      if (take_req && req.read) rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Side outputs, all registered
  input_port_pkg::pin_vec_t pu_nxt;
  input_port_pkg::pin_vec_t pd_nxt;
  wire wake_match;

  // A pin with both resistors fitted gets neither; sleep does not matter
  assign pu_nxt = pullup_fitted_option & ~pulldown_fitted_option
                & ~cfg_r.inhibit;
  assign pd_nxt = pulldown_fitted_option & ~pullup_fitted_option
                & ~cfg_r.inhibit;
  assign wake_match = (wake_pat_r != `PORT_ZERO)
                   && ((raw_r & wake_pat_r) == wake_pat_r);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_irq_pending_flags <= `PENDING_RST;
      pullup_en <= `PORT_ZERO;
      pulldown_en <= `PORT_ZERO;
      branch_test_one <= 1'b0;
      branch_test_two <= 1'b0;
      branch_test_three <= 1'b0;
      event_clk_pin0 <= 1'b0;
      event_clk_pin3 <= 1'b0;
      millisecond_counter_run <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      pin_irq_pending_flags <= pend_nxt;
      pullup_en <= pu_nxt;
      pulldown_en <= pd_nxt;
      branch_test_one <= deb_lvl[0];
      branch_test_two <= deb_lvl[1];
      branch_test_three <= deb_lvl[2];
      event_clk_pin0 <= oriented[0];
      event_clk_pin3 <= oriented[3];
      millisecond_counter_run <= raw_r[3];
      wake_request <= sleep_mode && wake_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_req_seen;
    any_req && avs_waitrequest;
  endsequence

  sequence s_answer_then_idle;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (s_req_seen |=> s_answer_then_idle)
    else $error("bus answer not given one cycle after request");

  AST_MASK_AFTER_RESET: assert property (
    @(posedge clk_sys) disable iff (1'b0) sys_rst |=> cfg_r.enable == `ENABLE_RST)
    else $error("enable bits not cleared by reset");

  AST_MASKED_NOT_STORED: assert property (
    ((pend_r & ~$past(pend_r) & ~$past(cfg_r.enable)) == `PORT_ZERO))
    else $error("flag set while pin was masked");

  AST_EDGE_SETS_FLAG: assert property (
    (edge_hit[0] && cfg_r.enable[0]) |=> pend_r[0] && pin_irq_pending_flags[0])
    else $error("enabled edge on pin 0 did not set its flag");

  AST_W1C_CLEARS: assert property (
    (wr_pending && wdata4[1] && !edge_hit[1]) |=> !pend_r[1])
    else $error("write one did not clear pin 1 flag");

  AST_PULL_EXCLUSIVE: assert property ((pullup_en & pulldown_en) == `PORT_ZERO)
    else $error("pull-up and pull-down both enabled");

  AST_BRANCH_FOLLOWS_DEB: assert property (
    ##1 (branch_test_two == $past(deb_lvl[1])))
    else $error("branch test two does not follow debounced pin 1");

  AST_MSC_RAW_PAD: assert property (
    $changed(input_port[3]) ##3 1'b1 |-> millisecond_counter_run == $past(input_port[3], 3))
    else $error("start/stop does not follow pin 3 pad");

  AST_WAKE_IN_SLEEP: assert property ((sleep_mode && wake_match) |=> wake_request)
    else $error("wake not raised on pattern match in sleep");

  AST_LEVEL_READBACK: assert property (
    (accept && avs_read && avs_address == `OFF_LEVELS)
      |-> avs_readdata[3:0] == $past(raw_r))
    else $error("level readback wrong");

  AST_PULL_NEEDS_FIT: assert property (
    ((pullup_en & ~pullup_fitted_option)
      | (pulldown_en & ~pulldown_fitted_option)) == `PORT_ZERO)
    else $error("pull enabled on a pin without that resistor");

  AST_PULL_INHIBITED: assert property (
    ((pullup_en | pulldown_en) & $past(cfg_r.inhibit)) == `PORT_ZERO)
    else $error("pull enabled on an inhibited pin");

  AST_SLEEP_KEEPS_PULL: assert property (
    (sleep_mode && $stable(cfg_r.inhibit) && !$past(sys_rst))
      |=> $stable(pullup_en) && $stable(pulldown_en))
    else $error("pull enables moved in sleep without a setting change");

  AST_NO_WAKE_AWAKE: assert property (!sleep_mode |=> !wake_request)
    else $error("wake raised outside sleep");

  AST_W1C_KEEPS_OTHERS: assert property (
    (wr_pending && !wdata4[2] && pend_r[2]) |=> pend_r[2])
    else $error("write zero cleared pin 2 flag");

  sequence s_flag3_sets;
    !pend_r[3] ##1 pend_r[3];
  endsequence

  AST_FLAG_NEEDS_EDGE: assert property (
    s_flag3_sets |-> $past(edge_hit[3] && cfg_r.enable[3]))
    else $error("pin 3 flag set without an enabled edge");

  AST_EVENT_RAW_ROUTE: assert property (
    (cfg_r.bypass[3] && !cfg_r.polarity[3]) |=> event_clk_pin3 == $past(raw_r[3]))
    else $error("event clock pin 3 does not follow raw input");

  AST_EVENT_DEB_ROUTE: assert property (
    !cfg_r.bypass[0] |=> event_clk_pin0 == ($past(deb_lvl[0]) ^ $past(cfg_r.polarity[0])))
    else $error("event clock pin 0 does not follow debounced input");

  AST_BRANCH_ONE_THREE: assert property (
    1'b1 |=> branch_test_one == $past(deb_lvl[0]) && branch_test_three == $past(deb_lvl[2]))
    else $error("branch tests one or three do not follow debounced pins");

endmodule

// [input_port_pkg.sv]
// Types shared by the input port block and its debouncer.
// Assumes input_port_defines.svh is on the include path.
`include "input_port_defines.svh"

package input_port_pkg;

  typedef logic [`PIN_COUNT-1:0] pin_vec_t;

  // Software configuration, one bit per pin in each field
  typedef struct packed {
    pin_vec_t enable;
    pin_vec_t polarity;
    pin_vec_t bypass;
    pin_vec_t inhibit;
  } port_cfg_t;

  // Avalon-MM request as seen by the slave
  typedef struct packed {
    logic [`ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [`DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } bus_req_t;

endpackage

// [pin_debouncer.sv]
// Debouncer for the four input pins.
// Assumes synchronised pin levels and a one-cycle tick on each rising edge
// of the selected debounce clock.
`timescale 1ns/10ps
`include "input_port_defines.svh"

module pin_debouncer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire input_port_pkg::pin_vec_t raw_lvl,
  input wire logic deb_tick,
  output input_port_pkg::pin_vec_t deb_lvl
);

  input_port_pkg::pin_vec_t deb_r;
  input_port_pkg::pin_vec_t cand_r;
  input_port_pkg::pin_vec_t seen_r;

  assign deb_lvl = deb_r;

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
      wire differs;
      wire confirm;
      assign differs = raw_lvl[i] != deb_r[i];
      // New level seen at two consecutive ticks
      assign confirm = differs && seen_r[i] && (cand_r[i] == raw_lvl[i]);

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          deb_r[i] <= 1'b0;
          cand_r[i] <= 1'b0;
          seen_r[i] <= 1'b0;
        end else if (deb_tick) begin
          deb_r[i] <= confirm ? raw_lvl[i] : deb_r[i];
          cand_r[i] <= raw_lvl[i];
          seen_r[i] <= differs && !confirm;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  AST_DEB_ONLY_ON_TICK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !deb_tick |=> deb_r == $past(deb_r))
    else $error("debounced level moved without a debounce tick");

endmodule

// [pin_switches.sv]
// Model of the switches wired to the four input port pins.
// Assumes the bench calls its tasks; levels change just after a clk_sys rise.
`timescale 1ns/10ps

module pin_switches (
  input wire logic clk_sys,
  output logic [3:0] pins
);
  initial pins = 4'h0;

  // Settle on a new level
  task automatic set(input logic [3:0] v);
    @(posedge clk_sys);
    pins <= v;
  endtask

  // Contact bounce: a short pulse on the masked pins, then back
  task automatic bounce(input logic [3:0] m, input int n);
    @(posedge clk_sys);
    pins <= pins ^ m;
    repeat (n) @(posedge clk_sys);
    pins <= pins ^ m;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the four-pin input port block.
// Assumes the defines header on the include path and the switch model.
`timescale 1ns/10ps
`include "input_port_defines.svh"

module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] input_port;
  logic tap_128hz;
  logic tap_1024hz;
  logic sleep_mode;
  logic [3:0] pin_irq_pending_flags, pullup_en, pulldown_en;
  logic branch_test_one, branch_test_two, branch_test_three;
  logic event_clk_pin0, event_clk_pin3, millisecond_counter_run, wake_request;
  logic [31:0] rd;
  logic [7:0] tap_cnt = 8'h00;
  int n_mismatch = 0;
  int num_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 clk_sys = ~clk_sys;

  // Scaled prescaler taps, 1024 Hz tap eight times the 128 Hz tap
  always @(posedge clk_sys) begin
    tap_cnt <= tap_cnt + 8'h01;
    tap_1024hz <= tap_cnt[2];
    tap_128hz <= tap_cnt[5];
  end

  input_port_irq_debounce input_port_irq_debounce_inst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .input_port(input_port),
    .tap_128hz(tap_128hz),
    .tap_1024hz(tap_1024hz),
    .sleep_mode(sleep_mode),
    .pin_irq_pending_flags(pin_irq_pending_flags),
    .pullup_en(pullup_en),
    .pulldown_en(pulldown_en),
    .branch_test_one(branch_test_one),
    .branch_test_two(branch_test_two),
    .branch_test_three(branch_test_three),
    .event_clk_pin0(event_clk_pin0),
    .event_clk_pin3(event_clk_pin3),
    .millisecond_counter_run(millisecond_counter_run),
    .wake_request(wake_request)
  );

  pin_switches pin_switches_inst (
    .clk_sys(clk_sys),
    .pins(input_port)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) n_mismatch++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(`OFF_ENABLE, 32'h0);
    rdc(`OFF_PENDING, 32'h0);
    rdc(`OFF_POLARITY, 32'h0);
    rdc(`OFF_BYPASS, 32'h0);
    rdc(`OFF_DIVIDER, 32'h0);
    chk(32'({pullup_en, pulldown_en}), 32'h0f);
  endtask

  task automatic t_raw_edges();
    wr(`OFF_BYPASS, 32'hf);
    wr(`OFF_ENABLE, 32'hf);
    pin_switches_inst.set(4'ha);
    cyc(8);
    chk(32'(pin_irq_pending_flags), 32'ha);
    chk(32'(millisecond_counter_run), 32'h1);
    rdc(`OFF_LEVELS, 32'ha);
    wr(`OFF_PENDING, 32'h2);
    rdc(`OFF_PENDING, 32'h8);
    wr(`OFF_PENDING, 32'h0);
    rdc(`OFF_PENDING, 32'h8);
    wr(`OFF_POLARITY, 32'ha);
    wr(`OFF_PENDING, 32'hf);
    pin_switches_inst.set(4'h0);
    cyc(8);
    chk(32'(pin_irq_pending_flags), 32'ha);
    chk(32'({event_clk_pin3, event_clk_pin0}), 32'h2);
    wr(`OFF_PENDING, 32'hf);
  endtask

  task automatic t_mask();
    wr(`OFF_ENABLE, 32'h0);
    wr(`OFF_POLARITY, 32'h0);
    pin_switches_inst.set(4'h1);
    cyc(8);
    wr(`OFF_ENABLE, 32'h1);
    rdc(`OFF_PENDING, 32'h0);
    pin_switches_inst.set(4'h0);
    cyc(8);
    wr(`OFF_POLARITY, 32'h1);
    cyc(4);
    rdc(`OFF_PENDING, 32'h1);
    wr(`OFF_POLARITY, 32'h0);
    wr(`OFF_PENDING, 32'hf);
  endtask

  task automatic t_debounce();
    wr(`OFF_BYPASS, 32'h0);
    wr(`OFF_ENABLE, 32'h4);
    cyc(150);
    pin_switches_inst.bounce(4'h2, 3);
    pin_switches_inst.set(4'h5);
    cyc(10);
    chk(32'(branch_test_one), 32'h0);
    cyc(150);
    chk(32'({branch_test_three, branch_test_two, branch_test_one}), 32'h5);
    chk(32'(pin_irq_pending_flags), 32'h4);
    chk(32'(event_clk_pin0), 32'h1);
    wr(`OFF_DIVIDER, 32'h1);
    pin_switches_inst.set(4'h2);
    cyc(30);
    chk(32'({branch_test_three, branch_test_two, branch_test_one}), 32'h2);
  endtask

  task automatic t_sleep();
    wr(`OFF_WAKE, 32'h6);
    wr(`OFF_INHIBIT, 32'h5);
    sleep_mode <= 1'b1;
    pin_switches_inst.set(4'h6);
    cyc(6);
    chk(32'(wake_request), 32'h1);
    chk(32'({pullup_en, pulldown_en}), 32'h0a);
    pin_switches_inst.set(4'h4);
    cyc(6);
    chk(32'(wake_request), 32'h0);
    sleep_mode <= 1'b0;
    rdc(`OFF_INHIBIT, 32'h5);
    rdc(5'h1e, 32'h0);
    avs_byteenable <= 4'he;
    wr(`OFF_INHIBIT, 32'h0);
    avs_byteenable <= 4'hf;
    rdc(`OFF_INHIBIT, 32'h5);
  endtask

  // Reset in mid-run clears enables and flags; pulls return to defaults
  task automatic t_rerst();
    wr(`OFF_ENABLE, 32'hf);
    wr(`OFF_INHIBIT, 32'h3);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rdc(`OFF_ENABLE, 32'h0);
    rdc(`OFF_PENDING, 32'h0);
    chk(32'({pullup_en, pulldown_en}), 32'h0f);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    avs_address <= 5'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'hf;
    sleep_mode <= 1'b0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_raw_edges();
    t_mask();
    t_debounce();
    t_rerst();
    t_sleep();
    finish_test();
  end

  // Whole run needs about 550 cycles; cut a hang at 20000
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
